// ===== inc/ccbg_cfg.svh
// Timing counts and sequence constants for the converter bus glue host
`ifndef CCBG_CFG_SVH
`define CCBG_CFG_SVH
// Functional notes
// - Memory placement: select from memory decode, load/store strobes drive read/start.
// - I/O placement: decode 8-bit port address from low or high address byte.
// - Select, read, start take standard strobes; start converts, read drives data.
// - With eight or fewer I/O devices, one low address bit selects each.
// - Simple variant: one port bit drives select; read, start, request wired direct.
// - Simple variant: dummy-address read makes read pulse, write makes start pulse.
// - Before first conversion, read once with select low to clear pending request.
// - Per sample: select, start, await request, read, deselect; sixteen samples.
// - Generic strobes gated with memory and I/O request lines give distinct strobes.
// - I/O-space strobes stretched by one inserted wait state of one clock.
// - Upper address byte on I/O input carries value, may be latched as channel.
// - Free-running: select low, start tied to request, node pulsed low after power-up.
`define CCBG_CLK_HZ        25000000
`define CCBG_STROBE_NS     300
`define CCBG_STROBE_CYC    ((`CCBG_STROBE_NS * 25 + 999) / 1000)
`define CCBG_WAIT_CYC      1
`define CCBG_SETUP_CYC     1
`define CCBG_SAMPLES       16
`define CCBG_TIMEOUT_CYC   8191
`define CCBG_FIFO_DEPTH    16
`define CCBG_DATA_W        8
`endif

// ===== inc/ccbg_pkg.sv
// Types for the converter bus glue host
package ccbg_pkg;
    typedef enum logic [1:0] {
        CCBG_MAP_MEM    = 2'h0,
        CCBG_MAP_IO     = 2'h1,
        CCBG_MAP_SIMPLE = 2'h3
    } ccbg_map_t;
    typedef enum logic [3:0] {
        CCBG_IDLE   = 4'h0,
        CCBG_CLRSEL = 4'h1,
        CCBG_CLRRD  = 4'h3,
        CCBG_SEL    = 4'h2,
        CCBG_START  = 4'h6,
        CCBG_WAIT   = 4'h7,
        CCBG_READ   = 4'h5,
        CCBG_PUSH   = 4'h4,
        CCBG_DESEL  = 4'hc,
        CCBG_FREE   = 4'hd
    } ccbg_state_t;
endpackage

// ===== test/ccbg_conv_model.sv
// Behavioural converter answering the host's select, read and start pins
`timescale 1ns/1ps
`default_nettype none
module ccbg_conv_model (
    // Clock
    input  wire logic       clock,
    // Control pins
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_node,
    // Test knobs
    input  wire logic       slow,
    input  wire logic       mute,
    // Answer pins
    output logic            intr_n,
    output logic      [7:0] data
);
    logic [7:0] latch       = 8'h00;
    logic [7:0] last        = 8'h00;
    logic [7:0] next_result = 8'h40;
    logic       wr_q        = 1'b1;
    int         cnt         = 0;
    wire        rd_sel      = !cs_n && !rd_n;
    wire        start       = !wr_q && wr_node && !cs_n;
    // ----
    // Conversion
    // ----
    initial intr_n = 1'b1;
    // A released bus shows the inverse of the last byte so a stale copy cannot pass
    assign data = rd_sel ? latch : ~last;
    always @(posedge clock) begin
        wr_q <= wr_node;
        // A low start with select drops the request, so a tied start/request node re-arms
        if (!cs_n && !wr_node) begin
            intr_n <= 1'b1;
        end
        if (rd_sel) begin
            last   <= latch;
            intr_n <= 1'b1;
        end
        if (start) begin
            // Restart drops the running conversion; the latch keeps the old byte
            intr_n <= 1'b1;
            cnt    <= slow ? 24 : 6;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1 && !mute) begin
                latch       <= next_result;
                next_result <= next_result + 8'h01;
                intr_n      <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/ccbg_host_checker.sv
// Port-level assertions for the converter bus glue host
`timescale 1ns/1ps
`default_nettype none
`include "ccbg_cfg.svh"
module ccbg_host_checker
    import ccbg_pkg::*;
#(
    parameter int         DATA_W    = 8,
    parameter logic [7:0] PORT_ADDR = 8'he0,
    parameter logic [2:0] SEL_BIT   = 3'h0
) (
    // Clock and reset
    input wire logic                clock,
    input wire logic                nrst,
    // User side
    input wire ccbg_pkg::ccbg_map_t map_mode,
    input wire logic                use_high_byte,
    input wire logic                one_hot_select,
    input wire logic                free_run,
    input wire logic                go,
    input wire logic [7:0]          channel,
    input wire logic                busy,
    input wire logic                sample_valid,
    input wire logic                sample_ready,
    input wire logic [DATA_W-1:0]   sample_data,
    // Bus and pins
    input wire logic [15:0]         bus_addr,
    input wire logic                memory_request_n,
    input wire logic                io_request_n,
    input wire logic                bus_rd_n,
    input wire logic                bus_wr_n,
    input wire logic                mem_load_strobe,
    input wire logic                mem_store_strobe,
    input wire logic                conv_cs_n,
    input wire logic                conv_rd_n,
    input wire logic                conv_wr_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // Length of the current low run of the read strobe, in clock cycles
    logic [4:0] rd_low_cnt;
    always_ff @(posedge clock) begin
        if (!nrst || conv_rd_n) begin
            rd_low_cnt <= '0;
        end else begin
            rd_low_cnt <= rd_low_cnt + 5'h01;
        end
    end
    // ----
    // Checks
    // ----
    AST_RESET_IDLE:
    assert property ($past(!nrst) |-> conv_cs_n && conv_rd_n && conv_wr_n && !busy && !sample_valid)
        else $error("pins not idle after reset");
    AST_RD_NEEDS_CS:
    assert property (!conv_rd_n |-> !conv_cs_n)
        else $error("read strobe without select");
    AST_RD_WR_APART:
    assert property (conv_rd_n || conv_wr_n)
        else $error("read and start strobes overlap");
    AST_START_AFTER_SEL:
    assert property ($fell(conv_wr_n) && !free_run |-> !$past(conv_cs_n) && (!conv_cs_n)[*8])
        else $error("start pulse without select setup");
    AST_CLEAR_READ_FIRST:
    assert property (go && !busy && !free_run |-> conv_wr_n throughout (1'b1 ##[2:4] !conv_rd_n))
        else $error("first strobe of a run is not a read");
    AST_MEM_STROBE:
    assert property ($fell(conv_rd_n) && map_mode == CCBG_MAP_MEM |-> (!conv_rd_n)[*8] ##1 conv_rd_n)
        else $error("memory read strobe length wrong");
    AST_IO_STRETCH:
    assert property ($rose(conv_rd_n) && map_mode == CCBG_MAP_IO |->
        rd_low_cnt == 5'(`CCBG_STROBE_CYC + `CCBG_WAIT_CYC))
        else $error("i/o read strobe not stretched by one cycle");
    AST_IO_ADDR:
    assert property (map_mode == CCBG_MAP_IO && !io_request_n |->
        bus_addr[7:0] == (one_hot_select ? (8'h01 << SEL_BIT) : PORT_ADDR) &&
        bus_addr[15:8] == (use_high_byte ? bus_addr[7:0] : channel))
        else $error("i/o port address wrong");
    AST_MEM_ADDR:
    assert property (!memory_request_n || (map_mode == CCBG_MAP_SIMPLE && !conv_cs_n) |->
        bus_addr == ((map_mode == CCBG_MAP_MEM) ? 16'h5000 : 16'h00ff))
        else $error("memory address wrong");
    AST_MEM_STROBES:
    assert property (map_mode == CCBG_MAP_MEM |->
        mem_load_strobe == conv_rd_n && mem_store_strobe == bus_wr_n)
        else $error("memory strobes do not follow read and start");
    AST_OTHER_QUIET:
    assert property (map_mode != CCBG_MAP_MEM |-> mem_load_strobe && mem_store_strobe)
        else $error("memory strobe outside memory placement");
    AST_BUS_RD:
    assert property (bus_rd_n == conv_rd_n)
        else $error("bus read strobe differs from converter read");
    AST_REQ_EXCL:
    assert property (memory_request_n || io_request_n)
        else $error("memory and i/o requests together");
    AST_HOLD_SAMPLE:
    assert property (sample_valid && !sample_ready |=> sample_valid && $stable(sample_data))
        else $error("offered sample dropped or changed");
endmodule
bind ccbg_host ccbg_host_checker #(.DATA_W(DATA_W), .PORT_ADDR(PORT_ADDR), .SEL_BIT(SEL_BIT))
    ccbg_host_checker_i (.clock(clock), .nrst(nrst), .map_mode(map_mode),
    .use_high_byte(use_high_byte), .one_hot_select(one_hot_select), .free_run(free_run),
    .go(go), .channel(channel), .busy(busy), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data), .bus_addr(bus_addr),
    .memory_request_n(memory_request_n), .io_request_n(io_request_n),
    .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
    .mem_load_strobe(mem_load_strobe), .mem_store_strobe(mem_store_strobe),
    .conv_cs_n(conv_cs_n), .conv_rd_n(conv_rd_n), .conv_wr_n(conv_wr_n));
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the converter bus glue host
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ccbg_pkg::*;
    logic       clock = 1'b0, nrst = 1'b0, go = 1'b0, free_run = 1'b0;
    logic       use_high_byte = 1'b0, one_hot_select = 1'b0, sample_ready = 1'b0;
    logic       slow = 1'b0, mute = 1'b0;
    logic [7:0] channel = 8'h00, expv = 8'h40;
    ccbg_map_t  map_mode = CCBG_MAP_MEM;
    logic       busy, timeout, sample_valid, conv_cs_n, conv_rd_n, conv_wr_n;
    logic       conv_wr_oe, conv_intr_n;
    logic [7:0] sample_data, conv_data, mux_channel;
    wire        wr_node;
    int         errors = 0, comparisons = 0;
    // Released start pin is the shared start/request node
    assign wr_node = conv_wr_oe ? conv_intr_n : conv_wr_n;
    ccbg_host #(.TIMEOUT(64), .PORT_ADDR(8'he0)) ccbg_host_i (.clock(clock), .nrst(nrst),
        .map_mode(map_mode),
        .use_high_byte(use_high_byte), .one_hot_select(one_hot_select), .free_run(free_run),
        .go(go), .channel(channel), .busy(busy), .timeout(timeout),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
        .bus_addr(), .memory_request_n(), .io_request_n(), .bus_rd_n(), .bus_wr_n(),
        .mem_load_strobe(), .mem_store_strobe(), .mux_channel(mux_channel),
        .conv_cs_n(conv_cs_n), .conv_rd_n(conv_rd_n), .conv_wr_n(conv_wr_n),
        .conv_wr_oe(conv_wr_oe), .conv_intr_n(conv_intr_n), .conv_data(conv_data));
    ccbg_conv_model ccbg_conv_model_i (.clock(clock), .cs_n(conv_cs_n), .rd_n(conv_rd_n),
        .wr_node(wr_node), .slow(slow), .mute(mute), .intr_n(conv_intr_n), .data(conv_data));
    // ----
    // Helpers
    // ----
    task automatic cmp1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic launch(input ccbg_map_t m);
        @(posedge clock);
        map_mode <= m;
        go       <= 1'b1;
        @(posedge clock);
        go       <= 1'b0;
    endtask
    task automatic wait_idle;
        int k;
        k = 0;
        @(negedge clock);
        while (busy !== 1'b0 && k < 9000) begin
            @(negedge clock);
            k++;
        end
        cmp1(busy, 1'b0);
    endtask
    // Pops n samples; a stall caps each wait so a lost sample still ends the task
    task automatic drain(input int n, input logic chk);
        int k;
        @(posedge clock);
        sample_ready <= 1'b1;
        for (int i = 0; i < n; i++) begin
            k = 0;
            @(negedge clock);
            while (sample_valid !== 1'b1 && k < 9000) begin
                @(negedge clock);
                k++;
            end
            cmp1(sample_valid, 1'b1);
            if (chk) begin
                cmp8(sample_data, expv);
                expv = expv + 8'h01;
            end
            @(posedge clock);
        end
        sample_ready <= 1'b0;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_mem;
        launch(CCBG_MAP_MEM);
        drain(16, 1'b1);
        wait_idle;
    endtask
    task automatic t_io;
        for (int c = 0; c < 3; c++) begin
            @(posedge clock);
            use_high_byte  <= c[0];
            one_hot_select <= c[1];
            channel        <= 8'h51 + 8'(c);
            launch(CCBG_MAP_IO);
            drain(16, 1'b1);
            wait_idle;
            // With the upper byte repeating the port, the port value is what gets latched
            cmp8(mux_channel, c[0] ? 8'he0 : 8'h51 + 8'(c));
        end
    endtask
    task automatic t_simple;
        @(posedge clock);
        slow <= 1'b1;
        launch(CCBG_MAP_SIMPLE);
        drain(16, 1'b1);
        wait_idle;
    endtask
    task automatic t_full;
        launch(CCBG_MAP_MEM);
        wait_idle;
        launch(CCBG_MAP_MEM);
        repeat (300) @(negedge clock);
        cmp1(busy, 1'b1);
        cmp1(conv_cs_n, 1'b0);
        drain(32, 1'b1);
        wait_idle;
    endtask
    task automatic t_timeout;
        @(posedge clock);
        mute <= 1'b1;
        launch(CCBG_MAP_MEM);
        drain(16, 1'b0);
        wait_idle;
        cmp1(timeout, 1'b1);
        @(posedge clock);
        nrst <= 1'b0;
        mute <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        cmp1(timeout, 1'b0);
    endtask
    // Free-run reads nothing; the request node pulsing low shows conversions keep coming
    task automatic t_free;
        int lows;
        lows = 0;
        @(posedge clock);
        free_run <= 1'b1;
        launch(CCBG_MAP_MEM);
        repeat (200) begin
            @(negedge clock);
            if (conv_intr_n === 1'b0) begin
                lows++;
            end
        end
        cmp1(busy, 1'b1);
        cmp1(conv_cs_n, 1'b0);
        cmp1(conv_wr_oe, 1'b1);
        cmp1(lows >= 5, 1'b1);
        @(posedge clock);
        free_run <= 1'b0;
        wait_idle;
    endtask
    initial begin
        forever #20 clock = ~clock;
    end
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        t_mem;
        t_io;
        t_simple;
        t_full;
        t_timeout;
        t_free;
        close_out;
    end
    initial begin
        repeat (40000) @(posedge clock);
        errors++;
        close_out;
    end
endmodule
`default_nettype wire

// ===== verilog/ccbg_fifo.sv
// Sample buffer between converter reads and the user side
`timescale 1ns/1ps
`default_nettype none
module ccbg_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = (count != (AW+1)'(D));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ===== verilog/ccbg_host.sv
// Host-side controller that drives the converter's control pins and collects samples
`timescale 1ns/1ps
`default_nettype none
`include "ccbg_cfg.svh"
module ccbg_host
    import ccbg_pkg::*;
#(
    parameter int DATA_W    = `CCBG_DATA_W,
    parameter int DEPTH     = `CCBG_FIFO_DEPTH,
    parameter int SAMPLES   = `CCBG_SAMPLES,
    parameter int TIMEOUT   = `CCBG_TIMEOUT_CYC,
    parameter logic [7:0] PORT_ADDR = 8'he0,
    parameter logic [2:0] SEL_BIT   = 3'h0
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              nrst,
    // User command side
    input  wire ccbg_pkg::ccbg_map_t map_mode,
    input  wire logic              use_high_byte,
    input  wire logic              one_hot_select,
    input  wire logic              free_run,
    input  wire logic              go,
    input  wire logic [7:0]        channel,
    output logic                   busy,
    output logic                   timeout,
    // Sample stream out
    output logic                   sample_valid,
    input  wire logic              sample_ready,
    output logic      [DATA_W-1:0] sample_data,
    // Emulated host bus towards decoder
    output logic      [15:0]       bus_addr,
    output logic                   memory_request_n,
    output logic                   io_request_n,
    output logic                   bus_rd_n,
    output logic                   bus_wr_n,
    output logic                   mem_load_strobe,
    output logic                   mem_store_strobe,
    output logic      [7:0]        mux_channel,
    // Converter pins
    output logic                   conv_cs_n,
    output logic                   conv_rd_n,
    output logic                   conv_wr_n,
    output logic                   conv_wr_oe,
    input  wire logic              conv_intr_n,
    input  wire logic [DATA_W-1:0] conv_data
);
    import ccbg_pkg::*;
    localparam int SW = 8;
    localparam int TW = 16;

    //--------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------
    logic              intr_s;
    logic [DATA_W-1:0] data_s;
    ccbg_sync #(.W(1 + DATA_W)) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .pin   ({conv_intr_n, conv_data}),
        .sync  ({intr_s, data_s})
    );

    //--------------------------------------------------------------
    // Sequencer state
    //--------------------------------------------------------------
    ccbg_state_t state;
    ccbg_state_t next_state;
    logic [TW-1:0] tmr;
    logic [SW-1:0] left;
    logic [DATA_W-1:0] hold;
    logic          fifo_ready;
    logic          strobe_done;
    logic          rd_phase;
    logic          wr_phase;
    logic          sel_on;

    // Strobe width plus the inserted wait state in I/O space
    wire [TW-1:0] strobe_len = (map_mode == CCBG_MAP_IO) ?
        TW'(`CCBG_STROBE_CYC + `CCBG_WAIT_CYC) : TW'(`CCBG_STROBE_CYC);
    // Timer starts at zero on entry, so the last strobe cycle is strobe_len - 1
    assign strobe_done = (tmr >= strobe_len - TW'(1));
    wire intr_seen = !intr_s;
    wire tmo_hit   = (tmr >= TW'(TIMEOUT));

    always_comb begin
        next_state = state;
        unique case (state)
            CCBG_IDLE:   if (go) next_state = free_run ? CCBG_FREE : CCBG_CLRSEL;
            CCBG_CLRSEL: next_state = CCBG_CLRRD;
            CCBG_CLRRD:  if (strobe_done) next_state = CCBG_SEL;
            CCBG_SEL:    if (tmr >= TW'(`CCBG_SETUP_CYC)) next_state = CCBG_START;
            CCBG_START:  if (strobe_done) next_state = CCBG_WAIT;
            CCBG_WAIT:   if (intr_seen || tmo_hit) next_state = CCBG_READ;
            CCBG_READ:   if (strobe_done) next_state = CCBG_PUSH;
            CCBG_PUSH:   if (fifo_ready) next_state = CCBG_DESEL;
            CCBG_DESEL:  next_state = (left == SW'(1)) ? CCBG_IDLE : CCBG_SEL;
            CCBG_FREE:   if (!free_run) next_state = CCBG_IDLE;
            default:     next_state = CCBG_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= CCBG_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst || next_state != state) begin
            tmr <= '0;
        end else if (tmr != '1) begin
            tmr <= tmr + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            left <= '0;
        end else if (state == CCBG_IDLE && go) begin
            left <= SW'(SAMPLES);
        end else if (state == CCBG_DESEL) begin
            left <= left - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            timeout <= 1'b0;
        end else if (state == CCBG_IDLE && go) begin
            timeout <= 1'b0;
        end else if (state == CCBG_WAIT && tmo_hit && !intr_seen) begin
            timeout <= 1'b1;
        end
    end

    // Result captured from the synchronised bus on the last read cycle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            hold <= '0;
        end else if (state == CCBG_READ && strobe_done) begin
            hold <= data_s;
        end
    end

    //--------------------------------------------------------------
    // Strobe and select decoding
    //--------------------------------------------------------------
    assign rd_phase = (state == CCBG_CLRRD) || (state == CCBG_READ);
    assign wr_phase = (state == CCBG_START);
    // Select stays low through the read and drops only in deselect
    assign sel_on   = (state != CCBG_IDLE) && (state != CCBG_DESEL)
                   && (state != CCBG_FREE);

    wire is_io  = (map_mode == CCBG_MAP_IO);
    wire is_mem = (map_mode == CCBG_MAP_MEM);
    wire [7:0] port_lo = one_hot_select ? (8'h01 << SEL_BIT) : PORT_ADDR;
    // In I/O input cycles the upper byte carries the channel value, or repeats the port when use_high_byte is set
    wire [15:0] io_addr = use_high_byte ? {port_lo, port_lo}
                                        : {channel, port_lo};
    wire [15:0] mem_addr = {8'h50, 8'h00};
    // Simple variant reaches the converter through a dummy external address
    wire [15:0] dummy_addr = {8'h00, 8'hff};
    wire [15:0] next_addr = is_io ? io_addr : (is_mem ? mem_addr : dummy_addr);
    wire rd_n = !(rd_phase && sel_on);
    wire wr_n = !(wr_phase && sel_on);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            bus_addr         <= '0;
            memory_request_n <= 1'b1;
            io_request_n     <= 1'b1;
            bus_rd_n         <= 1'b1;
            bus_wr_n         <= 1'b1;
            mem_load_strobe  <= 1'b1;
            mem_store_strobe <= 1'b1;
            mux_channel      <= '0;
        end else begin
            bus_addr         <= next_addr;
            memory_request_n <= !(is_mem && sel_on);
            io_request_n     <= !(is_io && sel_on);
            bus_rd_n         <= rd_n;
            bus_wr_n         <= wr_n;
            mem_load_strobe  <= !(is_mem && !rd_n);
            mem_store_strobe <= !(is_mem && !wr_n);
            if (is_io && !rd_n) begin
                mux_channel  <= io_addr[15:8];
            end
        end
    end

    //--------------------------------------------------------------
    // Converter pins
    //--------------------------------------------------------------
    logic free_kick;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            conv_cs_n  <= 1'b1;
            conv_rd_n  <= 1'b1;
            conv_wr_n  <= 1'b1;
            conv_wr_oe <= 1'b1;
            free_kick  <= 1'b0;
        end else if (state == CCBG_FREE) begin
            // Free-run: select held low, start node pulsed low once, then released
            conv_cs_n  <= 1'b0;
            conv_rd_n  <= 1'b1;
            free_kick  <= 1'b1;
            conv_wr_n  <= 1'b0;
            conv_wr_oe <= free_kick;
        end else begin
            conv_cs_n  <= !sel_on;
            conv_rd_n  <= rd_n;
            conv_wr_n  <= wr_n;
            conv_wr_oe <= 1'b0;
            free_kick  <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // Sample buffer
    //--------------------------------------------------------------
    ccbg_fifo #(.W(DATA_W), .D(DEPTH)) u_fifo (
        .clock     (clock),
        .nrst      (nrst),
        .in_valid  (state == CCBG_PUSH),
        .in_ready  (fifo_ready),
        .in_data   (hold),
        .out_valid (sample_valid),
        .out_ready (sample_ready),
        .out_data  (sample_data)
    );

    assign busy = (state != CCBG_IDLE);
endmodule
`default_nettype wire

// ===== verilog/ccbg_sync.sv
// Two-stage synchroniser for pin inputs, one flop pair per bit of a W-bit instance
`timescale 1ns/1ps
`default_nettype none
module ccbg_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // Pins in, synchronised out
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] sync
);
    logic [W-1:0] meta;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    meta[i] <= 1'b1;
                    sync[i] <= 1'b1;
                end else begin
                    meta[i] <= pin[i];
                    sync[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire
